/* core/add_and_compare_branch_exec.sv */
// Behaviour
// - adds write acc, carry and nibble carry
// - overflow is carry6 xor carry7
// - decode the four binary add forms
// - add with carry sums source, carry, acc
// - decode the four add with carry forms
// - page jump: pc+2, replace low eleven
// - byte and: no flags but parity
// - port read-modify-write reads output latch
// - decode four and-to-accumulator forms
// - decode two and-to-direct forms
// - bit and clears carry when the value used (source bit, complemented for /bit) is zero
// - decode true and complemented bit and
// - compare branch: pc past, add offset
// - compare sets carry when first smaller
// - decode compare with direct, three bytes
// - decode compare with immediate data
// - parity follows accumulator contents always
// - offset is one signed byte
`timescale 1ns/1ps
`default_nettype none
module add_and_compare_branch_exec (
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  input wire logic [1:0] bank_i,
  output logic pmem_rd_o,
  output logic [15:0] pmem_addr_o,
  input wire logic [7:0] pmem_data_i,
  input wire logic pmem_ack_i,
  output logic data_rd_o,
  output logic data_wr_o,
  output logic data_latch_o,
  output logic [7:0] data_addr_o,
  output logic [7:0] data_wdata_o,
  input wire logic [7:0] data_rdata_i,
  input wire logic data_ack_i,
  output logic bit_rd_o,
  output logic [7:0] bit_addr_o,
  input wire logic bit_rdata_i,
  input wire logic bit_ack_i,
  output logic [7:0] acc_o,
  output logic carry_flag_o,
  output logic nibble_carry_flag_o,
  output logic signed_overflow_flag_o,
  output logic parity_flag_o,
  output logic [15:0] program_counter_o,
  output logic instr_done_o,
  output logic unsupported_o
);
  import exec_pkg::*;

  typedef enum logic [2:0] {
    S_FETCH_OP, S_FETCH_B1, S_FETCH_B2, S_RD_PTR, S_RD_SRC, S_RD_BIT,
    S_EXEC, S_WRITE
  } state_t;

  state_t state_ff, nxt_state;
  decode_t dec_ff, nxt_dec;
  logic [15:0] pc_ff, nxt_pc;
  logic [7:0] op_ff, nxt_op;
  logic [7:0] b1_ff, nxt_b1;
  logic [7:0] b2_ff, nxt_b2;
  logic [7:0] src_ff, nxt_src;
  logic srcbit_ff, nxt_srcbit;
  logic [7:0] acc_ff, nxt_acc;
  logic cy_ff, nxt_cy;
  logic ac_ff, nxt_ac;
  logic ov_ff, nxt_ov;
  logic p_ff, nxt_p;
  logic [7:0] daddr_ff, nxt_daddr;
  logic [7:0] wdata_ff, nxt_wdata;
  logic latch_ff, nxt_latch;
  logic done_ff, nxt_done;
  logic unsup_ff, nxt_unsup;
  logic prd_ff, nxt_prd;
  logic drd_ff, nxt_drd;
  logic dwr_ff, nxt_dwr;
  logic brd_ff, nxt_brd;
  decode_t dec_now;

  exec_if ex ();

  add_unit u_add (
    .x(ex.alu_mp)
  );

  target_unit u_tgt (
    .x(ex.tgt_mp)
  );

  assign ex.acc = acc_ff;
  assign ex.src = src_ff;
  assign ex.cin = (dec_ff.cls == CLS_ADD_WITH_CARRY_IN) ? cy_ff : 1'b0;
  assign ex.pc = pc_ff;
  assign ex.op = op_ff;
  assign ex.addr_lo = b1_ff;
  assign ex.rel = b2_ff;

  // working register and pointer register live in the active bank
  function automatic logic [7:0] bank_addr(input logic [1:0] bank,
                                           input logic [2:0] idx);
    return {3'h0, bank, idx};
  endfunction

  always_comb begin
    nxt_state = state_ff;
    nxt_dec = dec_ff;
    nxt_pc = pc_ff;
    nxt_op = op_ff;
    nxt_b1 = b1_ff;
    nxt_b2 = b2_ff;
    nxt_src = src_ff;
    nxt_srcbit = srcbit_ff;
    nxt_acc = acc_ff;
    nxt_cy = cy_ff;
    nxt_ac = ac_ff;
    nxt_ov = ov_ff;
    nxt_daddr = daddr_ff;
    nxt_wdata = wdata_ff;
    nxt_latch = latch_ff;
    nxt_done = 1'b0;
    nxt_unsup = 1'b0;
    dec_now = decode_op(pmem_data_i);
    unique case (state_ff)
      S_FETCH_OP: begin
        if (pmem_ack_i) begin
          nxt_op = pmem_data_i;
          nxt_dec = dec_now;
          nxt_pc = pc_ff + 16'h0001;
          if (dec_now.cls == CLS_NONE) begin
            // foreign opcode: step over one byte and report it
            nxt_unsup = 1'b1;
            nxt_done = 1'b1;
          end else if (dec_now.nbytes != 2'h1) begin
            nxt_state = S_FETCH_B1;
          end else if (dec_now.mode == SRC_REG) begin
            nxt_daddr = bank_addr(bank_i, pmem_data_i[2:0]);
            nxt_latch = 1'b0;
            nxt_state = S_RD_SRC;
          end else begin
            nxt_daddr = bank_addr(bank_i, {2'h0, pmem_data_i[0]});
            nxt_latch = 1'b0;
            nxt_state = S_RD_PTR;
          end
        end
      end
      S_FETCH_B1: begin
        if (pmem_ack_i) begin
          nxt_b1 = pmem_data_i;
          nxt_pc = pc_ff + 16'h0001;
          nxt_src = pmem_data_i;
          nxt_daddr = pmem_data_i;
          // read-modify-write of a direct byte takes the port latch
          nxt_latch = dec_ff.cls inside {CLS_ANL_DA, CLS_ANL_DI};
          if (dec_ff.nbytes == 2'h3) begin
            nxt_state = S_FETCH_B2;
          end else if (dec_ff.cls == CLS_JMP || dec_ff.mode == SRC_IMM) begin
            nxt_state = S_EXEC;
          end else if (dec_ff.cls inside {CLS_ANL_CB, CLS_ANL_CNB}) begin
            nxt_state = S_RD_BIT;
          end else begin
            nxt_state = S_RD_SRC;
          end
        end
      end
      S_FETCH_B2: begin
        if (pmem_ack_i) begin
          nxt_b2 = pmem_data_i;
          nxt_pc = pc_ff + 16'h0001;
          nxt_state = (dec_ff.cls == CLS_CMP_I) ? S_EXEC : S_RD_SRC;
        end
      end
      S_RD_PTR: begin
        if (data_ack_i) begin
          nxt_daddr = data_rdata_i;
          nxt_state = S_RD_SRC;
        end
      end
      S_RD_SRC: begin
        if (data_ack_i) begin
          nxt_src = data_rdata_i;
          nxt_state = S_EXEC;
        end
      end
      S_RD_BIT: begin
        if (bit_ack_i) begin
          // complement applies to the value used only
          nxt_srcbit = (dec_ff.cls == CLS_ANL_CNB) ? ~bit_rdata_i
                                                   : bit_rdata_i;
          nxt_state = S_EXEC;
        end
      end
      S_EXEC: begin
        nxt_state = S_FETCH_OP;
        nxt_done = 1'b1;
        unique case (dec_ff.cls)
          CLS_ADD, CLS_ADD_WITH_CARRY_IN: begin
            nxt_acc = ex.sum;
            nxt_cy = ex.c7;
            nxt_ac = ex.c3;
            nxt_ov = ex.ov;
          end
          CLS_JMP: nxt_pc = ex.page_target;
          CLS_ANL_A: nxt_acc = acc_ff & src_ff;
          CLS_ANL_DA, CLS_ANL_DI: begin
            nxt_wdata = src_ff & ((dec_ff.cls == CLS_ANL_DA) ? acc_ff
                                                             : b2_ff);
            nxt_daddr = b1_ff;
            nxt_done = 1'b0;
            nxt_state = S_WRITE;
          end
          CLS_ANL_CB, CLS_ANL_CNB: begin
            if (!srcbit_ff) nxt_cy = 1'b0;
          end
          CLS_CMP_D, CLS_CMP_I: begin
            nxt_cy = acc_ff < src_ff;
            if (acc_ff != src_ff) nxt_pc = ex.rel_target;
          end
          default: begin
          end
        endcase
      end
      S_WRITE: begin
        if (data_ack_i) begin
          nxt_done = 1'b1;
          nxt_state = S_FETCH_OP;
        end
      end
    endcase
    nxt_p = ^nxt_acc;
    // strobes follow the next state so they leave straight from flops
    nxt_prd = nxt_state inside {S_FETCH_OP, S_FETCH_B1, S_FETCH_B2};
    nxt_drd = nxt_state inside {S_RD_PTR, S_RD_SRC};
    nxt_dwr = nxt_state == S_WRITE;
    nxt_brd = nxt_state == S_RD_BIT;
  end

  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      state_ff <= S_FETCH_OP;
      dec_ff <= '{cls: CLS_NONE, mode: SRC_IMM, nbytes: 2'h1};
      pc_ff <= PC_RESET;
      op_ff <= 8'h00;
      b1_ff <= 8'h00;
      b2_ff <= 8'h00;
      src_ff <= 8'h00;
      srcbit_ff <= 1'b0;
      acc_ff <= ACC_RESET;
      cy_ff <= 1'b0;
      ac_ff <= 1'b0;
      ov_ff <= 1'b0;
      p_ff <= 1'b0;
      daddr_ff <= 8'h00;
      wdata_ff <= 8'h00;
      latch_ff <= 1'b0;
      done_ff <= 1'b0;
      unsup_ff <= 1'b0;
      // reset state is the opcode fetch, so the fetch strobe starts high
      prd_ff <= 1'b1;
      drd_ff <= 1'b0;
      dwr_ff <= 1'b0;
      brd_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      dec_ff <= nxt_dec;
      pc_ff <= nxt_pc;
      op_ff <= nxt_op;
      b1_ff <= nxt_b1;
      b2_ff <= nxt_b2;
      src_ff <= nxt_src;
      srcbit_ff <= nxt_srcbit;
      acc_ff <= nxt_acc;
      cy_ff <= nxt_cy;
      ac_ff <= nxt_ac;
      ov_ff <= nxt_ov;
      p_ff <= nxt_p;
      daddr_ff <= nxt_daddr;
      wdata_ff <= nxt_wdata;
      latch_ff <= nxt_latch;
      done_ff <= nxt_done;
      unsup_ff <= nxt_unsup;
      prd_ff <= nxt_prd;
      drd_ff <= nxt_drd;
      dwr_ff <= nxt_dwr;
      brd_ff <= nxt_brd;
    end
  end

  // no decode behind the strobes: a glitch here would fake a request
  assign pmem_rd_o = prd_ff;
  assign pmem_addr_o = pc_ff;
  assign data_rd_o = drd_ff;
  assign data_wr_o = dwr_ff;
  assign data_latch_o = latch_ff;
  assign data_addr_o = daddr_ff;
  assign data_wdata_o = wdata_ff;
  assign bit_rd_o = brd_ff;
  assign bit_addr_o = b1_ff;
  assign acc_o = acc_ff;
  assign carry_flag_o = cy_ff;
  assign nibble_carry_flag_o = ac_ff;
  assign signed_overflow_flag_o = ov_ff;
  assign parity_flag_o = p_ff;
  assign program_counter_o = pc_ff;
  assign instr_done_o = done_ff;
  assign unsupported_o = unsup_ff;

endmodule // add_and_compare_branch_exec
`default_nettype wire

/* core/add_unit.sv */
`timescale 1ns/1ps
`default_nettype none
module add_unit (
  exec_if.alu_mp x
);
  import exec_pkg::*;
  logic [8:0] full;
  logic [4:0] low4;
  logic [7:0] low7;

  always_comb begin
    full = {1'b0, x.acc} + {1'b0, x.src} + {8'h00, x.cin};
    low4 = {1'b0, x.acc[3:0]} + {1'b0, x.src[3:0]} + {4'h0, x.cin};
    low7 = {1'b0, x.acc[6:0]} + {1'b0, x.src[6:0]} + {7'h00, x.cin};
  end

  assign x.sum = full[7:0];
  assign x.c7 = full[8];
  assign x.c3 = low4[4];
  assign x.ov = low7[7] ^ full[8];
endmodule // add_unit
`default_nettype wire

/* core/exec_if.sv */
`timescale 1ns/1ps
`default_nettype none
interface exec_if;
  logic [7:0] acc;
  logic [7:0] src;
  logic cin;
  logic [7:0] sum;
  logic c7;
  logic c3;
  logic ov;
  logic [15:0] pc;
  logic [7:0] op;
  logic [7:0] addr_lo;
  logic [7:0] rel;
  logic [15:0] page_target;
  logic [15:0] rel_target;

  modport core_mp (output acc, src, cin, pc, op, addr_lo, rel,
                   input sum, c7, c3, ov, page_target, rel_target);
  modport alu_mp (input acc, src, cin, output sum, c7, c3, ov);
  modport tgt_mp (input pc, op, addr_lo, rel,
                  output page_target, rel_target);
endinterface
`default_nettype wire

/* core/exec_pkg.sv */
package exec_pkg;

  localparam int PC_W = 16;
  localparam logic [15:0] PC_RESET = 16'h0000;
  localparam logic [7:0] ACC_RESET = 8'h00;

  // opcode encodings
  localparam logic [7:0] OP_ADD_IMM = 8'h24;
  localparam logic [7:0] OP_ADD_DIR = 8'h25;
  localparam logic [7:0] OP_ADD_WITH_CARRY_IN_IMM = 8'h34;
  localparam logic [7:0] OP_ADD_WITH_CARRY_IN_DIR = 8'h35;
  localparam logic [7:0] OP_ANL_DIR_A = 8'h52;
  localparam logic [7:0] OP_ANL_DIR_IMM = 8'h53;
  localparam logic [7:0] OP_ANL_IMM = 8'h54;
  localparam logic [7:0] OP_ANL_DIR = 8'h55;
  localparam logic [7:0] OP_ANL_BIT = 8'h82;
  localparam logic [7:0] OP_ANL_NBIT = 8'hb0;
  localparam logic [7:0] OP_CMP_IMM = 8'hb4;
  localparam logic [7:0] OP_CMP_DIR = 8'hb5;
  localparam logic [4:0] JMP_LOW = 5'h01;

  // working register address inside the data space: bank in bits 4:3
  localparam int BANK_LSB = 3;

  typedef enum logic [3:0] {
    CLS_NONE, CLS_ADD, CLS_ADD_WITH_CARRY_IN, CLS_JMP, CLS_ANL_A, CLS_ANL_DA,
    CLS_ANL_DI, CLS_ANL_CB, CLS_ANL_CNB, CLS_CMP_D, CLS_CMP_I
  } cls_t;

  typedef enum logic [1:0] {SRC_REG, SRC_DIR, SRC_IND, SRC_IMM} src_mode_t;

  typedef struct packed {
    cls_t cls;
    src_mode_t mode;
    logic [1:0] nbytes;
  } decode_t;

  // four source forms shared by add, add with carry and and-to-acc
  function automatic src_mode_t acc_src(input logic [7:0] op);
    if (op[3]) return SRC_REG;
    if (op[1]) return SRC_IND;
    if (op[0]) return SRC_DIR;
    return SRC_IMM;
  endfunction

  function automatic decode_t decode_op(input logic [7:0] op);
    decode_t d;
    d = '{cls: CLS_NONE, mode: SRC_IMM, nbytes: 2'h1};
    if (op[4:0] == JMP_LOW) begin
      d = '{cls: CLS_JMP, mode: SRC_IMM, nbytes: 2'h2};
    end else if (op[7:4] == 4'h2 && (op[3] || op[2])) begin
      d.cls = CLS_ADD;
    end else if (op[7:4] == 4'h3 && (op[3] || op[2])) begin
      d.cls = CLS_ADD_WITH_CARRY_IN;
    end else if (op[7:4] == 4'h5 && (op[3] || op[2])) begin
      d.cls = CLS_ANL_A;
    end else if (op == OP_ANL_DIR_A) begin
      d = '{cls: CLS_ANL_DA, mode: SRC_DIR, nbytes: 2'h2};
    end else if (op == OP_ANL_DIR_IMM) begin
      d = '{cls: CLS_ANL_DI, mode: SRC_DIR, nbytes: 2'h3};
    end else if (op == OP_ANL_BIT) begin
      d = '{cls: CLS_ANL_CB, mode: SRC_DIR, nbytes: 2'h2};
    end else if (op == OP_ANL_NBIT) begin
      d = '{cls: CLS_ANL_CNB, mode: SRC_DIR, nbytes: 2'h2};
    end else if (op == OP_CMP_DIR) begin
      d = '{cls: CLS_CMP_D, mode: SRC_DIR, nbytes: 2'h3};
    end else if (op == OP_CMP_IMM) begin
      d = '{cls: CLS_CMP_I, mode: SRC_IMM, nbytes: 2'h3};
    end
    if (d.cls inside {CLS_ADD, CLS_ADD_WITH_CARRY_IN, CLS_ANL_A}) begin
      d.mode = acc_src(op);
      d.nbytes = (d.mode == SRC_DIR || d.mode == SRC_IMM) ? 2'h2 : 2'h1;
    end
    return d;
  endfunction

endpackage

/* core/target_unit.sv */
`timescale 1ns/1ps
`default_nettype none
module target_unit (
  exec_if.tgt_mp x
);
  import exec_pkg::*;
  // pc arriving here already points past the whole instruction
  assign x.page_target = {x.pc[15:11], x.op[7:5], x.addr_lo};
  assign x.rel_target = x.pc + {{8{x.rel[7]}}, x.rel};
endmodule // target_unit
`default_nettype wire

/* dv/add_and_compare_branch_exec_bench.sv */
`timescale 1ns/1ps
`default_nettype none
module add_and_compare_branch_exec_bench;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [1:0] bank = 2'h0;
  logic slow = 1'b0;
  logic prd, pack, drd, dwr, lat, dack, brd, bdat, back;
  logic cy, nc, ov, par, done, uns;
  logic [15:0] paddr, pc;
  logic [7:0] pdat, daddr, dwd, drdat, baddr, acc;
  logic [15:0] epc = 16'h0;
  logic [7:0] ea = 8'h0;
  logic ec = 1'b0;
  logic eac = 1'b0;
  logic eov = 1'b0;
  logic [31:0] seed = 32'h60fd;
  int num_errors = 0;
  int checked = 0;
  logic [7:0] ops [20] = '{8'h24, 8'h25, 8'h26, 8'h28, 8'h34, 8'h35,
    8'h36, 8'h38, 8'h52, 8'h53, 8'h54, 8'h55, 8'h56, 8'h58, 8'h82,
    8'hb0, 8'hb4, 8'hb5, 8'h01, 8'h00};
  add_and_compare_branch_exec DUT (.sys_clk_i(clk), .rst_n_i(rst_n),
    .bank_i(bank), .pmem_rd_o(prd), .pmem_addr_o(paddr),
    .pmem_data_i(pdat), .pmem_ack_i(pack), .data_rd_o(drd),
    .data_wr_o(dwr), .data_latch_o(lat), .data_addr_o(daddr),
    .data_wdata_o(dwd), .data_rdata_i(drdat), .data_ack_i(dack),
    .bit_rd_o(brd), .bit_addr_o(baddr), .bit_rdata_i(bdat),
    .bit_ack_i(back), .acc_o(acc), .carry_flag_o(cy),
    .nibble_carry_flag_o(nc), .signed_overflow_flag_o(ov),
    .parity_flag_o(par), .program_counter_o(pc), .instr_done_o(done),
    .unsupported_o(uns));
  mem_model mem (.clk_i(clk), .slow_i(slow), .prd_i(prd), .paddr_i(paddr),
    .pdata_o(pdat), .pack_o(pack), .drd_i(drd), .dwr_i(dwr),
    .daddr_i(daddr), .dwdata_i(dwd), .drdata_o(drdat), .dack_o(dack),
    .brd_i(brd), .baddr_i(baddr), .bdata_o(bdat), .back_o(back));
  function automatic logic [31:0] xs(input logic [31:0] v);
    v = v ^ (v << 13);
    v = v ^ (v >> 17);
    return v ^ (v << 5);
  endfunction
  // {overflow, nibble carry, carry, sum}
  function automatic logic [10:0] add_exp(input logic [7:0] a, s,
                                          input logic c);
    logic [8:0] t;
    logic h, l;
    t = a + s + c;
    h = (a[3:0] + s[3:0] + c) > 5'hf;
    l = (a[6:0] + s[6:0] + c) > 8'h7f;
    return {t[8] ^ l, h, t};
  endfunction
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp) begin
      num_errors++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic final_report;
    $display("checks %0d mismatches %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  // places one instruction at the predicted pc and checks its outcome
  task automatic run(input logic [7:0] op, b2, b3);
    logic [7:0] s, d;
    logic c, u;
    int n, w;
    mem.pm[epc] = op;
    mem.pm[epc + 16'h1] = b2;
    mem.pm[epc + 16'h2] = b3;
    s = op[3] ? mem.dm[{3'h0, bank, op[2:0]}]
      : op[1] ? mem.dm[mem.dm[{3'h0, bank, 2'h0, op[0]}]]
      : op[0] ? mem.dm[b2] : b2;
    d = mem.dm[b2];
    n = (op[3] || op[1]) ? 1 : 2;
    c = op[4] & ec;
    u = 1'b0;
    if (op[4:0] == 5'h01) begin
      n = 0;
      epc = epc + 16'h2;
      epc[10:0] = {op[7:5], b2};
    end else if (op[7:5] == 3'h1)
      {eov, eac, ec, ea} = add_exp(ea, s, c);
    else if (op == 8'h52 || op == 8'h53) begin
      d = d & (op[0] ? b3 : ea);
      n = op[0] ? 3 : 2;
    end else if (op[7:4] == 4'h5)
      ea = ea & s;
    else if (op == 8'h82 || op == 8'hb0) begin
      ec = ec & (mem.bm[b2] ^ op[5]);
      n = 2;
    end else if (op[7:1] == 7'h5a) begin
      ec = ea < s;
      n = 3;
      if (ea != s)
        epc = epc + {{8{b3[7]}}, b3};
    end else begin
      u = 1'b1;
      n = 1;
    end
    epc = epc + 16'(n);
    w = 0;
    do begin
      @(negedge clk);
      w++;
    end while (done !== 1'b1 && w < 300);
    chk({15'h0000, done}, 16'h0001);
    chk(acc, ea);
    chk({cy, nc, ov, par}, {ec, eac, eov, ^ea});
    chk(pc, epc);
    chk(mem.dm[b2], d);
    chk(uns, u);
  endtask
  initial begin
    forever #2.5 clk = ~clk;
  end
  initial begin
    #200000;
    num_errors++;
    final_report();
  end
  initial begin
    logic [7:0] op;
    for (int i = 0; i < 256; i++) begin
      seed = xs(seed);
      mem.dm[i] = seed[7:0];
      mem.bm[i] = seed[8];
    end
    repeat (20) @(negedge clk);
    rst_n = 1'b1;
    run(8'h24, 8'hc3, 8'h00);
    bank = 2'h2;
    mem.dm[8'h10] = 8'haa;
    run(8'h28, 8'h00, 8'h00);
    // second jump crosses into the next page
    run(8'he1, 8'hfe, 8'h00);
    run(8'h21, 8'h34, 8'h00);
    run(8'hb4, ea, 8'h80);
    run(8'hb4, ea + 8'h1, 8'h80);
    run(8'h00, 8'h00, 8'h00);
    $display("test corners done");
    for (int i = 0; i < 300; i++) begin
      seed = xs(seed);
      op = ops[seed[15:0] % 20];
      if (op[3] && !op[7])
        op[2:0] = seed[18:16];
      if (op[3:1] == 3'h3 && !op[7])
        op[0] = seed[19];
      if (op == 8'h01)
        op[7:5] = seed[22:20];
      bank = seed[24:23];
      slow = seed[25];
      seed = xs(seed);
      run(op, seed[7:0], seed[15:8]);
    end
    $display("test random done");
    final_report();
  end
endmodule // add_and_compare_branch_exec_bench
`default_nettype wire

/* dv/exec_monitor.sv */
`timescale 1ns/1ps
`default_nettype none
module exec_monitor (
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  input wire logic pmem_rd_o,
  input wire logic [15:0] pmem_addr_o,
  input wire logic [7:0] pmem_data_i,
  input wire logic pmem_ack_i,
  input wire logic data_rd_o,
  input wire logic data_wr_o,
  input wire logic data_latch_o,
  input wire logic data_ack_i,
  input wire logic bit_rdata_i,
  input wire logic bit_ack_i,
  input wire logic [7:0] acc_o,
  input wire logic carry_flag_o,
  input wire logic signed_overflow_flag_o,
  input wire logic parity_flag_o,
  input wire logic [15:0] program_counter_o,
  input wire logic instr_done_o
);
  logic [1:0] n_ff;
  logic [7:0] op_ff, b2_ff;
  logic [15:0] at_ff;
  logic bit_ff, lat_ff;
  wire fa = pmem_rd_o && pmem_ack_i;
  wire first = fa && (instr_done_o || n_ff == 2'h0);
  wire [15:0] nx = at_ff + 16'h2;
  // byte count since last completion tells opcode from operands
  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      n_ff <= 2'h0;
      lat_ff <= 1'b0;
    end else begin
      if (instr_done_o)
        n_ff <= {1'b0, fa};
      else if (fa && n_ff != 2'h3)
        n_ff <= n_ff + 2'h1;
      if (first)
        op_ff <= pmem_data_i;
      if (first)
        at_ff <= pmem_addr_o;
      if (fa && !instr_done_o && n_ff == 2'h1)
        b2_ff <= pmem_data_i;
      if (bit_ack_i)
        bit_ff <= bit_rdata_i;
      if (instr_done_o)
        lat_ff <= 1'b0;
      else if (data_rd_o && data_ack_i)
        lat_ff <= data_latch_o;
    end
  end
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!rst_n_i);
  a_parity_tracks_acc: assert property (
    parity_flag_o == ^acc_o) else $error("parity differs from acc");
  a_fetch_holds: assert property (
    pmem_rd_o && !pmem_ack_i |=> pmem_rd_o && $stable(pmem_addr_o))
    else $error("fetch dropped before ack");
  a_fetch_steps: assert property (
    fa |=> pmem_addr_o == $past(pmem_addr_o) + 16'h1)
    else $error("fetch address did not step");
  a_acc_at_commit: assert property (
    $changed(acc_o) |-> instr_done_o) else $error("acc moved early");
  a_write_from_latch: assert property (
    data_wr_o |-> lat_ff) else $error("write not after latch read");
  a_and_keeps_flags: assert property (
    instr_done_o && op_ff[7:4] == 4'h5 |-> $stable(carry_flag_o)
    && $stable(signed_overflow_flag_o)) else $error("and moved flags");
  a_page_jump_target: assert property (
    instr_done_o && op_ff[4:0] == 5'h01 |->
    program_counter_o == {nx[15:11], op_ff[7:5], b2_ff})
    else $error("page jump target wrong");
  a_bit_and_carry: assert property (
    instr_done_o && (op_ff == 8'h82 || op_ff == 8'hb0) |->
    carry_flag_o == ($past(carry_flag_o) & (bit_ff ^ op_ff[5])))
    else $error("bit and carry wrong");
  a_compare_carry: assert property (
    instr_done_o && op_ff == 8'hb4 |->
    carry_flag_o == (acc_o < b2_ff) && $stable(acc_o))
    else $error("compare carry wrong");
  c_page_jump: cover property (instr_done_o && op_ff[4:0] == 5'h01);
  c_direct_write: cover property (data_wr_o && data_ack_i);
  c_compare: cover property (instr_done_o && op_ff == 8'hb5);
endmodule // exec_monitor
bind add_and_compare_branch_exec exec_monitor mon (.sys_clk_i, .rst_n_i,
  .pmem_rd_o, .pmem_addr_o, .pmem_data_i, .pmem_ack_i, .data_rd_o,
  .data_wr_o, .data_latch_o, .data_ack_i, .bit_rdata_i, .bit_ack_i, .acc_o,
  .carry_flag_o, .signed_overflow_flag_o, .parity_flag_o,
  .program_counter_o, .instr_done_o);
`default_nettype wire

/* dv/mem_model.sv */
`timescale 1ns/1ps
`default_nettype none
module mem_model (
  input wire logic clk_i,
  input wire logic slow_i,
  input wire logic prd_i,
  input wire logic [15:0] paddr_i,
  output logic [7:0] pdata_o,
  output logic pack_o,
  input wire logic drd_i,
  input wire logic dwr_i,
  input wire logic [7:0] daddr_i,
  input wire logic [7:0] dwdata_i,
  output logic [7:0] drdata_o,
  output logic dack_o,
  input wire logic brd_i,
  input wire logic [7:0] baddr_i,
  output logic bdata_o,
  output logic back_o
);
  logic [7:0] pm [65536];
  logic [7:0] dm [256];
  logic bm [256];
  logic [3:0] cnt = 4'h0;
  // slow mode answers one cycle in four
  wire go = !slow_i || cnt[1:0] == 2'h3;
  always @(posedge clk_i) begin
    cnt <= cnt + 4'h1;
    if (dwr_i && dack_o)
      dm[daddr_i] <= dwdata_i;
  end
  // unanswered lines show garbage, never the held value
  assign pack_o = prd_i && go;
  assign pdata_o = pack_o ? pm[paddr_i] : ~pm[paddr_i] ^ {4'h0, cnt};
  assign dack_o = (drd_i || dwr_i) && go;
  assign drdata_o = dack_o ? dm[daddr_i] : ~dm[daddr_i];
  assign back_o = brd_i && go;
  assign bdata_o = back_o ? bm[baddr_i] : ~bm[baddr_i];
endmodule // mem_model
`default_nettype wire
